// [rtl/sea_pkg.sv]
package sea_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STS_GPIO3_TACH = 6'h13;
  localparam logic [5:0] IDX_STS_GPIO5 = 6'h14;
  localparam logic [5:0] IDX_STS_GPIO1 = 6'h15;
  localparam logic [5:0] IDX_EN_PERIPH = 6'h16;
  localparam logic [5:0] IDX_EN_MISC = 6'h17;
  localparam logic [5:0] IDX_EN_GPIO2 = 6'h18;
  localparam logic [5:0] IDX_EN_GPIO3_TACH = 6'h19;
  localparam logic [5:0] IDX_EN_GPIO5 = 6'h1A;
  localparam logic [5:0] IDX_EN_GPIO1 = 6'h1B;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

  // Values after reset
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;

  // Implemented bits of the peripheral and misc enable registers
  localparam logic [7:0] EN_PERIPH_MASK = 8'h9E;
  localparam logic [7:0] EN_MISC_MASK = 8'hDF;
  localparam logic [4:0] EN_MISC_SRC_MASK = 5'h1F;

  // Misc enable register fields
  localparam int EN_MISC_SERIRQ_BIT = 6;
  localparam int EN_MISC_PIN_BIT = 7;

  // Interrupt status fields
  localparam int IRQ_GPIO3_TACH_BIT = 0;
  localparam int IRQ_GPIO5_BIT = 1;
  localparam int IRQ_GPIO1_BIT = 2;
  localparam int IRQ_SMI_RISE_BIT = 3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sea_pkg

// [rtl/sea_sync.sv]
module sea_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule : sea_sync

// [rtl/sea_smi_aggregator.sv]
// How it works
// - Each GPIO or tachometer status bit latches its input event for software.
// - GPIO and tachometer status bits clear only on a written one; zero leaves them alone.
// - An enable bit of one passes its source; zero blocks it.
// - Misc enable register bits 0 to 4 gate mouse, keyboard, SMBus, ring, port12.
// - Misc enable bit 6 puts the combined SMI into the serial IRQ stream.
// - Misc enable bit 7 drives the combined SMI onto the SMI pin.
// - With pin routing off, the SMI pin is not driven at all.
module sea_smi_aggregator
  import sea_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Event pins: GPIO groups and fan tachometer
  input wire logic [7:0] gpio3TachPins,
  input wire logic [7:0] gpio5Pins,
  input wire logic [7:0] gpio1Pins,
  input wire logic [7:0] gpio2Pins,
  // Same-clock source levels
  input wire logic [7:0] periphSrc,
  input wire logic [4:0] miscSrc,
  // SMI outputs
  output logic combinedSmi,
  output logic smiPinN,
  output logic smiPinOe,
  output logic serirqSmi,
  output logic irq
);
  logic [7:0] gpio3Sync, gpio5Sync, gpio1Sync, gpio2Sync;
  logic [7:0] sts4, sts5, sts6, en1, en2, en3, en4, en5, en6;
  logic [7:0] next_sts4, next_sts5, next_sts6, next_en1, next_en2, next_en3;
  logic [7:0] next_en4, next_en5, next_en6;
  logic [3:0] irqSts, irqMask, next_irqSts, next_irqMask, irqEvent;
  logic awHeld, wHeld, next_awHeld, next_wHeld;
  logic [ADDR_W-1:0] awAddrQ, next_awAddrQ;
  logic [7:0] wDataQ, next_wDataQ;
  logic wStrbQ, next_wStrbQ;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic doWrite, readStatus, combAct;
  logic [5:0] wrIdx, rdIdx;
  logic [7:0] wrOnes4, wrOnes5, wrOnes6;
  logic next_combinedSmi, next_smiPinN, next_smiPinOe, next_serirqSmi, next_irq;

  // Pins pass two flops before use
  sea_sync #(.W(32)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({gpio2Pins, gpio1Pins, gpio5Pins, gpio3TachPins}),
    .q({gpio2Sync, gpio1Sync, gpio5Sync, gpio3Sync})
  );

  function automatic logic reg_hit(input logic [5:0] idx);
    case (idx)
      IDX_STS_GPIO3_TACH, IDX_STS_GPIO5, IDX_STS_GPIO1, IDX_EN_PERIPH, IDX_EN_MISC,
      IDX_EN_GPIO2, IDX_EN_GPIO3_TACH, IDX_EN_GPIO5, IDX_EN_GPIO1, IDX_IRQ_STATUS,
      IDX_IRQ_MASK: reg_hit = 1'b1;
      default: reg_hit = 1'b0;
    endcase
  endfunction : reg_hit

  // Write path: address and data taken in either order
  assign wrIdx = awAddrQ[7:2];
  assign rdIdx = araddr[7:2];
  assign doWrite = awHeld && wHeld && !bvalid;

  always_comb begin
    next_awHeld = awHeld;
    next_wHeld = wHeld;
    next_awAddrQ = awAddrQ;
    next_wDataQ = wDataQ;
    next_wStrbQ = wStrbQ;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (awvalid && awready) begin
      next_awHeld = 1'b1;
      next_awAddrQ = awaddr;
    end
    if (wvalid && wready) begin
      next_wHeld = 1'b1;
      next_wDataQ = wdata[7:0];
      next_wStrbQ = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (doWrite) begin
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_hit(wrIdx) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_awHeld;
    next_wready = !next_wHeld;
  end

  // Read path: one read at a time, data registered
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    readStatus = 1'b0;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp = reg_hit(rdIdx) ? RESP_OKAY : RESP_SLVERR;
      readStatus = (rdIdx == IDX_IRQ_STATUS);
      case (rdIdx)
        IDX_STS_GPIO3_TACH: next_rdata = {24'h00_0000, sts4};
        IDX_STS_GPIO5: next_rdata = {24'h00_0000, sts5};
        IDX_STS_GPIO1: next_rdata = {24'h00_0000, sts6};
        IDX_EN_PERIPH: next_rdata = {24'h00_0000, en1};
        IDX_EN_MISC: next_rdata = {24'h00_0000, en2};
        IDX_EN_GPIO2: next_rdata = {24'h00_0000, en3};
        IDX_EN_GPIO3_TACH: next_rdata = {24'h00_0000, en4};
        IDX_EN_GPIO5: next_rdata = {24'h00_0000, en5};
        IDX_EN_GPIO1: next_rdata = {24'h00_0000, en6};
        IDX_IRQ_STATUS: next_rdata = {28'h000_0000, irqSts};
        IDX_IRQ_MASK: next_rdata = {28'h000_0000, irqMask};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // Register file
  always_comb begin
    wrOnes4 = 8'h00;
    wrOnes5 = 8'h00;
    wrOnes6 = 8'h00;
    next_en1 = en1;
    next_en2 = en2;
    next_en3 = en3;
    next_en4 = en4;
    next_en5 = en5;
    next_en6 = en6;
    next_irqMask = irqMask;
    if (doWrite && wStrbQ) begin
      case (wrIdx)
        IDX_STS_GPIO3_TACH: wrOnes4 = wDataQ;
        IDX_STS_GPIO5: wrOnes5 = wDataQ;
        IDX_STS_GPIO1: wrOnes6 = wDataQ;
        IDX_EN_PERIPH: next_en1 = wDataQ & EN_PERIPH_MASK;
        IDX_EN_MISC: next_en2 = wDataQ & EN_MISC_MASK;
        IDX_EN_GPIO2: next_en3 = wDataQ;
        IDX_EN_GPIO3_TACH: next_en4 = wDataQ;
        IDX_EN_GPIO5: next_en5 = wDataQ;
        IDX_EN_GPIO1: next_en6 = wDataQ;
        IDX_IRQ_MASK: next_irqMask = wDataQ[3:0];
        default: next_en1 = en1;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_sts4 = (sts4 & ~wrOnes4) | gpio3Sync;
    next_sts5 = (sts5 & ~wrOnes5) | gpio5Sync;
    next_sts6 = (sts6 & ~wrOnes6) | gpio1Sync;
    irqEvent[IRQ_GPIO3_TACH_BIT] = |(gpio3Sync & ~sts4);
    irqEvent[IRQ_GPIO5_BIT] = |(gpio5Sync & ~sts5);
    irqEvent[IRQ_GPIO1_BIT] = |(gpio1Sync & ~sts6);
    irqEvent[IRQ_SMI_RISE_BIT] = combAct && !combinedSmi;
    next_irqSts = (readStatus ? RST_IRQ : irqSts) | irqEvent;
  end

  // OR of all enabled sources
  assign combAct = |(sts4 & en4) | |(sts5 & en5) | |(sts6 & en6)
    | |(gpio2Sync & en3) | |(periphSrc & en1 & EN_PERIPH_MASK)
    | |(miscSrc & en2[4:0] & EN_MISC_SRC_MASK);

  // Pin enable trails the routing bit by one cycle
  always_comb begin
    next_combinedSmi = combAct;
    next_smiPinN = !combAct;
    next_smiPinOe = en2[EN_MISC_PIN_BIT];
    next_serirqSmi = combAct && en2[EN_MISC_SERIRQ_BIT];
    next_irq = |(irqSts & irqMask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= '0;
      wDataQ <= RST_REG8;
      wStrbQ <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
      sts4 <= RST_REG8;
      sts5 <= RST_REG8;
      sts6 <= RST_REG8;
      en1 <= RST_REG8;
      en2 <= RST_REG8;
      en3 <= RST_REG8;
      en4 <= RST_REG8;
      en5 <= RST_REG8;
      en6 <= RST_REG8;
      irqSts <= RST_IRQ;
      irqMask <= RST_IRQ;
      combinedSmi <= 1'b0;
      smiPinN <= 1'b1;
      smiPinOe <= 1'b0;
      serirqSmi <= 1'b0;
      irq <= 1'b0;
    end else begin
      awHeld <= next_awHeld;
      wHeld <= next_wHeld;
      awAddrQ <= next_awAddrQ;
      wDataQ <= next_wDataQ;
      wStrbQ <= next_wStrbQ;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      sts4 <= next_sts4;
      sts5 <= next_sts5;
      sts6 <= next_sts6;
      en1 <= next_en1;
      en2 <= next_en2;
      en3 <= next_en3;
      en4 <= next_en4;
      en5 <= next_en5;
      en6 <= next_en6;
      irqSts <= next_irqSts;
      irqMask <= next_irqMask;
      combinedSmi <= next_combinedSmi;
      smiPinN <= next_smiPinN;
      smiPinOe <= next_smiPinOe;
      serirqSmi <= next_serirqSmi;
      irq <= next_irq;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_STS_LATCH: assert property (
    (gpio3Sync != 8'h00) |=> ((sts4 & $past(gpio3Sync)) == $past(gpio3Sync))
  ) else $error("status bit missed its event");

  AST_STS_HOLD: assert property (
    !(doWrite && wrIdx == IDX_STS_GPIO5) |=> ((sts5 & $past(sts5)) == $past(sts5))
  ) else $error("status bit dropped without a written one");

  AST_STS_W1C: assert property (
    (doWrite && wStrbQ && wrIdx == IDX_STS_GPIO1)
      |=> ((sts6 & $past(wDataQ) & ~$past(gpio1Sync)) == 8'h00)
  ) else $error("written one did not clear status bit");

  AST_GATE_ON: assert property (
    ((sts4 & en4) != 8'h00) |=> combinedSmi
  ) else $error("enabled set source did not assert SMI");

  AST_GATE_OFF: assert property (
    (sts4 == 8'h00 && sts5 == 8'h00 && sts6 == 8'h00 && en3 == 8'h00
      && en1 == 8'h00 && en2[4:0] == 5'h00) |=> !combinedSmi
  ) else $error("SMI asserted with all sources blocked");

  AST_EN_MISC_RSV: assert property (
    (doWrite && wStrbQ && wrIdx == IDX_EN_MISC)
      |=> !en2[5] && (en2[4:0] == $past(wDataQ[4:0]))
  ) else $error("misc enable register field wrong");

  AST_SERIRQ: assert property (
    $rose(serirqSmi) |-> combinedSmi && $past(en2[EN_MISC_SERIRQ_BIT])
  ) else $error("serial IRQ SMI without its enable");

  AST_PIN_DRIVE: assert property (
    smiPinOe |-> (smiPinN == !combinedSmi)
  ) else $error("SMI pin level differs from combined SMI");

  AST_PIN_FLOAT: assert property (
    !en2[EN_MISC_PIN_BIT] |=> !smiPinOe
  ) else $error("SMI pin driven while routing disabled");

  AST_BRESP: assert property (
    (doWrite |=> bvalid) and ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
      and ((bvalid && bready) |=> !bvalid)
  ) else $error("write response timing wrong");

  AST_RD_ANSWER: assert property (
    (arvalid && arready) |=> rvalid && !arready
  ) else $error("read answer late");

  COV_PIN_SMI: cover property (smiPinOe && !smiPinN);
  COV_SERIRQ: cover property (serirqSmi);
  COV_W1C: cover property (doWrite && wrIdx == IDX_STS_GPIO3_TACH ##1 sts4 == 8'h00);
  COV_IRQ: cover property (irq ##[1:4] (rvalid && rready));
endmodule : sea_smi_aggregator

// [testbench/sea_host_model.sv]
module sea_host_model (
  // Lines from the device
  input wire logic smiPinN,
  input wire logic smiPinOe,
  input wire logic serirqSmi,
  // What the host sees
  output logic pinLevel,
  output logic hostSmi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board pull-up, so a floating pin never reads as an SMI
  assign pinLevel = smiPinOe ? smiPinN : 1'b1;
  // Host acts on either route
  assign hostSmi = !pinLevel || serirqSmi;
endmodule : sea_host_model

// [testbench/smi_status_enable_aggregator_bench.sv]
module smi_status_enable_aggregator_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import sea_pkg::*;
  typedef struct packed {
    logic [5:0] idx;
    logic [7:0] wr;
    logic [7:0] rd;
    logic [1:0] resp;
  } sea_row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [3:0] wrStrb = 4'hF;
  logic [7:0] gpio3TachPins = '0, gpio5Pins = '0, gpio1Pins = '0, gpio2Pins = '0;
  logic [7:0] periphSrc = '0;
  logic [4:0] miscSrc = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic combinedSmi, smiPinN, smiPinOe, serirqSmi, irq, pinLevel, hostSmi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [1:0] rsp;
  int failures = 0;
  int total_checks = 0;
  logic [5:0] gateIdx[3] = '{IDX_EN_PERIPH, IDX_EN_MISC, IDX_EN_GPIO2};
  logic [7:0] gateMask[3] = '{EN_PERIPH_MASK, 8'h1F, 8'hFF};
  sea_row_t rows[9] = '{
    '{IDX_EN_PERIPH, 8'hFF, EN_PERIPH_MASK, RESP_OKAY},
    '{IDX_EN_MISC, 8'hFF, EN_MISC_MASK, RESP_OKAY},
    '{IDX_EN_GPIO2, 8'hA5, 8'hA5, RESP_OKAY},
    '{IDX_EN_GPIO3_TACH, 8'h5A, 8'h5A, RESP_OKAY},
    '{IDX_EN_GPIO5, 8'h3C, 8'h3C, RESP_OKAY},
    '{IDX_EN_GPIO1, 8'hC3, 8'hC3, RESP_OKAY},
    '{IDX_IRQ_MASK, 8'hFF, 8'h0F, RESP_OKAY},
    '{IDX_STS_GPIO1, 8'hFF, 8'h00, RESP_OKAY},
    '{6'h3F, 8'h55, 8'h00, RESP_SLVERR}
  };

  sea_smi_aggregator dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .gpio3TachPins, .gpio5Pins, .gpio1Pins, .gpio2Pins, .periphSrc, .miscSrc,
    .combinedSmi, .smiPinN, .smiPinOe, .serirqSmi, .irq);
  sea_host_model host (.smiPinN, .smiPinOe, .serirqSmi, .pinLevel, .hostSmi);

  initial begin
    forever #25 clk = !clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s: saw %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wrReg(input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, d};
    wstrb <= wrStrb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [5:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : rdReg

  task automatic results;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Span covers roughly fifteen times the expected run
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    results();
  end

  initial begin
    cyc(6);
    rst <= 1'b0;
    @(posedge clk);
    chk(smiPinOe, 1'b0, "pin driven after reset");
    chk(irq, 1'b0, "irq after reset");
    foreach (rows[i]) begin
      rdReg(rows[i].idx);
      chk(rd, 32'h0000_0000, "reset value");
      wrReg(rows[i].idx, rows[i].wr);
      chk(32'(rsp), 32'(rows[i].resp), "write response");
      rdReg(rows[i].idx);
      chk(rd, {24'h00_0000, rows[i].rd}, "readback");
      chk(32'(rsp), 32'(rows[i].resp), "read response");
      wrReg(rows[i].idx, 8'h00);
    end
    $display("register rows done");
    // Events: status latch, W1C, interrupt raise and clear
    wrReg(IDX_IRQ_MASK, 8'h0F);
    gpio3TachPins <= 8'h20;
    gpio5Pins <= 8'h81;
    @(posedge clk);
    gpio3TachPins <= 8'h00;
    gpio5Pins <= 8'h00;
    cyc(5);
    chk(irq, 1'b1, "irq raised");
    rdReg(IDX_STS_GPIO3_TACH);
    chk(rd, 32'h0000_0020, "tach status");
    rdReg(IDX_IRQ_STATUS);
    chk(rd, 32'h0000_0003, "irq status");
    cyc(3);
    chk(irq, 1'b0, "irq after status read");
    wrReg(IDX_STS_GPIO3_TACH, 8'hDF);
    rdReg(IDX_STS_GPIO3_TACH);
    chk(rd, 32'h0000_0020, "zero write kept bit");
    wrReg(IDX_STS_GPIO3_TACH, 8'h20);
    rdReg(IDX_STS_GPIO3_TACH);
    chk(rd, 32'h0000_0000, "one write cleared bit");
    wrReg(IDX_STS_GPIO5, 8'h01);
    rdReg(IDX_STS_GPIO5);
    chk(rd, 32'h0000_0080, "partial clear");
    wrReg(IDX_IRQ_MASK, 8'h00);
    gpio1Pins <= 8'h01;
    @(posedge clk);
    gpio1Pins <= 8'h00;
    cyc(5);
    chk(irq, 1'b0, "masked irq");
    rdReg(IDX_IRQ_STATUS);
    chk(rd, 32'h0000_0004, "masked irq status");
    wrReg(IDX_STS_GPIO1, 8'h01);
    $display("event tests done");
    // Level sources gated one enable bit at a time
    periphSrc <= 8'hFF;
    miscSrc <= 5'h1F;
    gpio2Pins <= 8'hFF;
    cyc(5);
    chk(combinedSmi, 1'b0, "all enables off");
    for (int i = 0; i < 8; i++) begin
      for (int r = 0; r < 3; r++) begin
        wrReg(gateIdx[r], 8'h01 << i);
        cyc(3);
        chk(combinedSmi, gateMask[r][i], "single enable gate");
        wrReg(gateIdx[r], 8'h00);
      end
    end
    periphSrc <= 8'h00;
    miscSrc <= 5'h00;
    gpio2Pins <= 8'h00;
    wrReg(IDX_EN_GPIO5, 8'h7F);
    cyc(3);
    chk(combinedSmi, 1'b0, "status without enable");
    rdReg(IDX_IRQ_STATUS);
    chk(rd, 32'h0000_0008, "gating rise events");
    wrReg(IDX_EN_GPIO5, 8'h80);
    cyc(3);
    chk(combinedSmi, 1'b1, "status with enable");
    rdReg(IDX_IRQ_STATUS);
    chk(rd, 32'h0000_0008, "smi rise event");
    $display("gating tests done");
    // Routing of the combined signal
    for (int k = 0; k < 4; k++) begin
      wrReg(IDX_EN_MISC, {k[1:0], 6'h00});
      cyc(3);
      chk(serirqSmi, k[0], "serial route");
      chk(smiPinOe, k[1], "pin drive");
      chk(pinLevel, !k[1], "pin level");
      chk(hostSmi, k != 0, "host sees SMI");
    end
    wrReg(IDX_STS_GPIO5, 8'h80);
    cyc(3);
    chk(combinedSmi, 1'b0, "cleared status drops SMI");
    chk(smiPinN, 1'b1, "pin released high");
    chk(serirqSmi, 1'b0, "serial route idle");
    $display("routing tests done");
    // Awkward cases: strobe off, reset in mid-run
    wrStrb = 4'h0;
    wrReg(IDX_EN_GPIO2, 8'h33);
    wrStrb = 4'hF;
    chk(32'(rsp), 32'(RESP_OKAY), "strobe-off write response");
    rdReg(IDX_EN_GPIO2);
    chk(rd, 32'h0000_0000, "strobe-off write ignored");
    wrReg(IDX_EN_GPIO2, 8'hA5);
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    chk(smiPinOe, 1'b0, "pin floats after mid-run reset");
    chk(awready, 1'b0, "address held off in reset");
    rdReg(IDX_EN_MISC);
    chk(rd, 32'h0000_0000, "misc enable after mid-run reset");
    rdReg(IDX_EN_GPIO2);
    chk(rd, 32'h0000_0000, "gpio2 enable after mid-run reset");
    $display("awkward tests done");
    results();
  end
endmodule : smi_status_enable_aggregator_bench
